// file: logic/pswc_top.sv
// power-state and wake controller: switch timing, wake qualification, sensors, fans, registers
// Function
// R1 - short switch press: soft-off to working, working to sleep, sleep to working
// R2 - switch held over four seconds in working or sleep forces soft-off
// R3 - lan and pme wake from S1, S3, S4; from S5 only when enabled
// R4 - the S5 lan/pme wake enable resets to disabled
// R5 - setting the S5 wake option lets lan wake the system from S5
// R6 - switch, rtc alarm and pcie wake wake from S1, S3, S4, S5 always
// R7 - keyboard, serial and usb activity wake only from S1 and S3
// R8 - closed cover switch reports chassis intrusion
// R9 - four supply rails flagged when any leaves its window
// R10 - three fans under thermally driven closed-loop speed control
// R11 - software requests every power state change except switch and wake events
// R12 - software command gives soft-off, removing system power
// R13 - fans run only in S0 and S1, off otherwise
// R14 - pme wakes only when the wake-on-pme enable is set
// R15 - wake sources and intrusion latch in sticky flags until software clears
`timescale 1ns/1ps
module pswc_top #(
    parameter logic [pswc_pkg::HOLD_CW-1:0] HOLD_CYC = pswc_pkg::HOLD_CYC_DEF[pswc_pkg::HOLD_CW-1:0]
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic pwr_switch,
    input wire logic rtc_alarm,
    input wire logic pcie_wake,
    input wire logic lan_wake,
    input wire logic pme_wake,
    input wire logic kbms_act,
    input wire logic serial_act,
    input wire logic usb_act,
    input wire logic cover_closed,
    input wire logic [3:0] rail_high,
    input wire logic [3:0] rail_low,
    input wire logic [23:0] fan_temp,
    output pswc_pkg::pswc_state_t sys_state,
    output logic main_power_on,
    output logic intrusion,
    output logic volt_fault,
    output logic [2:0] fan_pwm,
    output logic irq
);
    import pswc_pkg::*;

    pswc_state_t state_r, state_nxt;
    logic [HOLD_CW-1:0] hold_r, hold_nxt;
    logic sw_prev_r, sw_prev_nxt;
    logic forced_r, forced_nxt;
    logic [1:0] cfg_r, cfg_nxt;
    logic [ST_W-1:0] status_r, status_nxt;
    logic [ST_W-1:0] mask_r, mask_nxt;
    logic [23:0] fan_tgt_r, fan_tgt_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic power_r, power_nxt;
    logic intr_r, intr_nxt;
    logic volt_r, volt_nxt;
    logic irq_r, irq_nxt;
    logic [ST_W-1:0] events;
    logic sleeping, shallow, s5_lan_ok, pme_ok;
    logic short_press, long_hold, wake_any;
    logic fan_run;
    logic [15:0] live_word;

    // state class decode
    always_comb
    begin
        sleeping = (state_r == PS_S1) || (state_r == PS_S3) || (state_r == PS_S4);
        shallow = (state_r == PS_S1) || (state_r == PS_S3);
        s5_lan_ok = sleeping || (state_r == PS_S5 && cfg_r[CFG_S5_LAN]);   // [R3] [R5]
        pme_ok = cfg_r[CFG_PME_EN] && s5_lan_ok;   // [R14]
        // a press is judged on release, when its length is known; a forced hold never counts
        short_press = sw_prev_r && !pwr_switch && !forced_r;   // [R1]
        long_hold = pwr_switch && !forced_r && (hold_r == HOLD_CYC - 1'b1) && (state_r != PS_S5);   // [R2]
    end

    // event qualification by current state
    always_comb
    begin
        events = '0;
        events[ST_SWITCH] = short_press && (sleeping || state_r == PS_S5);   // [R6]
        events[ST_RTC] = rtc_alarm && (sleeping || state_r == PS_S5);   // [R6]
        events[ST_PCIE] = pcie_wake && (sleeping || state_r == PS_S5);   // [R6]
        events[ST_LAN] = lan_wake && s5_lan_ok;   // [R3]
        events[ST_PME] = pme_wake && pme_ok;   // [R3] [R14]
        events[ST_KBMS] = kbms_act && shallow;   // [R7]
        events[ST_SERIAL] = serial_act && shallow;   // [R7]
        events[ST_USB] = usb_act && shallow;   // [R7]
        // level sensors set their sticky bits again every cycle the condition holds
        events[ST_INTRUDE] = cover_closed;   // [R8]
        events[ST_VOLT] = |(rail_high | rail_low);   // [R9]
        events[ST_FORCED] = long_hold;
        wake_any = |events[ST_USB:ST_SWITCH];
    end

    // power state machine and switch timer
    always_comb
    begin
        state_nxt = state_r;
        sw_prev_nxt = pwr_switch;
        // the hold timer saturates so a very long hold cannot wrap and fire again
        hold_nxt = pwr_switch ? ((hold_r == HOLD_CYC - 1'b1) ? hold_r : hold_r + 1'b1) : '0;
        // forced_r masks the release edge so a forced soft-off is not undone
        forced_nxt = pwr_switch ? (forced_r || long_hold) : 1'b0;
        if (long_hold)
        begin
            state_nxt = PS_S5;   // [R2]
        end
        else if (wake_any)
        begin
            state_nxt = PS_S0;   // [R1] [R6]
        end
        else if (short_press && state_r == PS_S0)
        begin
            state_nxt = PS_S1;   // [R1]
        end
        else if (reg_wr && reg_addr == OFS_CMD && state_r == PS_S0)
        begin
            // software-directed transitions [R11]
            // commands are taken only while working; sleep and off ignore them
            case (reg_wdata[2:0])
                CMD_SLEEP_S1: state_nxt = PS_S1;
                CMD_SLEEP_S3: state_nxt = PS_S3;
                CMD_SLEEP_S4: state_nxt = PS_S4;
                CMD_SOFT_OFF: state_nxt = PS_S5;   // [R12]
                default: state_nxt = state_r;
            endcase
        end
        // main power follows the next state so it switches on the same edge as sys_state
        power_nxt = (state_nxt == PS_S0) || (state_nxt == PS_S1);   // [R12]
        intr_nxt = cover_closed;   // [R8]
        volt_nxt = events[ST_VOLT];   // [R9]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            state_r <= PS_S5;
            hold_r <= '0;
            sw_prev_r <= 1'b0;
            forced_r <= 1'b0;
            power_r <= 1'b0;
            intr_r <= 1'b0;
            volt_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            hold_r <= hold_nxt;
            sw_prev_r <= sw_prev_nxt;
            forced_r <= forced_nxt;
            power_r <= power_nxt;
            intr_r <= intr_nxt;
            volt_r <= volt_nxt;
        end
    end

    // live view: rail flags, fan run, main power and intrusion
    always_comb
    begin
        live_word = 16'h0000;
        live_word[LV_RAIL +: 4] = rail_high | rail_low;
        live_word[LV_FAN] = fan_run;
        live_word[LV_POWER] = power_r;
        live_word[LV_INTR] = intr_r;
    end

    // register file, sticky status cleared on read, set wins
    always_comb
    begin
        cfg_nxt = cfg_r;
        mask_nxt = mask_r;
        fan_tgt_nxt = fan_tgt_r;
        status_nxt = status_r;
        // read data stand only in the cycle after the strobe, zero otherwise
        rdata_nxt = 16'h0000;
        if (reg_wr)
        begin
            if (reg_addr == OFS_CFG)
            begin
                cfg_nxt = reg_wdata[1:0];
            end
            else if (reg_addr == OFS_MASK)
            begin
                mask_nxt = reg_wdata[ST_W-1:0];
            end
            else if (reg_addr == OFS_FAN0)
            begin
                fan_tgt_nxt[7:0] = reg_wdata[7:0];
            end
            else if (reg_addr == OFS_FAN1)
            begin
                fan_tgt_nxt[15:8] = reg_wdata[7:0];
            end
            else if (reg_addr == OFS_FAN2)
            begin
                fan_tgt_nxt[23:16] = reg_wdata[7:0];
            end
        end
        if (reg_rd)
        begin
            if (reg_addr == OFS_STATE)
            begin
                rdata_nxt = {13'h0000, state_r};
            end
            else if (reg_addr == OFS_CFG)
            begin
                rdata_nxt = {14'h0000, cfg_r};
            end
            else if (reg_addr == OFS_STATUS)
            begin
                rdata_nxt = {5'h00, status_r};
                // an event in the same cycle still lands below: set wins over clear
                status_nxt = '0;   // [R15]
            end
            else if (reg_addr == OFS_MASK)
            begin
                rdata_nxt = {5'h00, mask_r};
            end
            else if (reg_addr == OFS_FAN0)
            begin
                rdata_nxt = {8'h00, fan_tgt_r[7:0]};
            end
            else if (reg_addr == OFS_FAN1)
            begin
                rdata_nxt = {8'h00, fan_tgt_r[15:8]};
            end
            else if (reg_addr == OFS_FAN2)
            begin
                rdata_nxt = {8'h00, fan_tgt_r[23:16]};
            end
            else if (reg_addr == OFS_LIVE)
            begin
                rdata_nxt = live_word;
            end
        end
        status_nxt = status_nxt | events;   // [R15]
        // mask_r is used, so a mask write shows on irq one cycle later
        irq_nxt = |(status_nxt & mask_r);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            cfg_r <= CFG_RST;   // [R4]
            mask_r <= MASK_RST;
            fan_tgt_r <= {3{FAN_RST}};
            status_r <= '0;
            rdata_r <= 16'h0000;
            irq_r <= 1'b0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            mask_r <= mask_nxt;
            fan_tgt_r <= fan_tgt_nxt;
            status_r <= status_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    // fans run only while working or in S1
    assign fan_run = (state_r == PS_S0) || (state_r == PS_S1);   // [R13]

    pswc_fan u_fan0 (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .run(fan_run),
        .temp(fan_temp[7:0]),
        .target(fan_tgt_r[7:0]),
        .pwm(fan_pwm[0])
    );   // [R10]

    pswc_fan u_fan1 (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .run(fan_run),
        .temp(fan_temp[15:8]),
        .target(fan_tgt_r[15:8]),
        .pwm(fan_pwm[1])
    );   // [R10]

    pswc_fan u_fan2 (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .run(fan_run),
        .temp(fan_temp[23:16]),
        .target(fan_tgt_r[23:16]),
        .pwm(fan_pwm[2])
    );   // [R10]

    assign sys_state = state_r;
    assign main_power_on = power_r;
    assign intrusion = intr_r;
    assign volt_fault = volt_r;
    assign reg_rdata = rdata_r;
    assign irq = irq_r;
endmodule : pswc_top

// file: logic/pswc_pkg.sv
// package: constants, register map and state encoding for the power-state wake controller
package pswc_pkg;
    // timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned HOLD_MS = 4000;
    localparam int unsigned HOLD_CYC_DEF = (CLK_HZ / 1000) * HOLD_MS;
    localparam int unsigned HOLD_CW = 26;

    // register offsets
    localparam logic [3:0] OFS_STATE = 4'h0;
    localparam logic [3:0] OFS_CMD = 4'h1;
    localparam logic [3:0] OFS_CFG = 4'h2;
    localparam logic [3:0] OFS_STATUS = 4'h3;
    localparam logic [3:0] OFS_MASK = 4'h4;
    localparam logic [3:0] OFS_FAN0 = 4'h5;
    localparam logic [3:0] OFS_FAN1 = 4'h6;
    localparam logic [3:0] OFS_FAN2 = 4'h7;
    localparam logic [3:0] OFS_LIVE = 4'h8;

    // status / mask bit positions
    localparam int unsigned ST_SWITCH = 0;
    localparam int unsigned ST_RTC = 1;
    localparam int unsigned ST_PCIE = 2;
    localparam int unsigned ST_LAN = 3;
    localparam int unsigned ST_PME = 4;
    localparam int unsigned ST_KBMS = 5;
    localparam int unsigned ST_SERIAL = 6;
    localparam int unsigned ST_USB = 7;
    localparam int unsigned ST_INTRUDE = 8;
    localparam int unsigned ST_VOLT = 9;
    localparam int unsigned ST_FORCED = 10;
    localparam int unsigned ST_W = 11;

    // live status bit positions
    localparam int unsigned LV_INTR = 0;
    localparam int unsigned LV_POWER = 1;
    localparam int unsigned LV_FAN = 2;
    localparam int unsigned LV_RAIL = 9;

    // config bit positions
    localparam int unsigned CFG_S5_LAN = 0;
    localparam int unsigned CFG_PME_EN = 1;

    // reset values
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic [ST_W-1:0] MASK_RST = 11'h000;
    localparam logic [7:0] FAN_RST = 8'h00;

    // command codes written to OFS_CMD
    localparam logic [2:0] CMD_SLEEP_S1 = 3'h1;
    localparam logic [2:0] CMD_SLEEP_S3 = 3'h2;
    localparam logic [2:0] CMD_SLEEP_S4 = 3'h3;
    localparam logic [2:0] CMD_SOFT_OFF = 3'h4;

    // system states, gray along s5 -> s0 -> s1 -> s3 -> s4
    typedef enum logic [2:0] {
        PS_S5 = 3'b000,
        PS_S0 = 3'b001,
        PS_S1 = 3'b011,
        PS_S3 = 3'b010,
        PS_S4 = 3'b110
    } pswc_state_t;
endpackage : pswc_pkg

// file: logic/pswc_fan.sv
// one closed-loop fan channel: pwm duty tracks temperature against a target
`timescale 1ns/1ps
module pswc_fan (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [7:0] temp,
    input wire logic [7:0] target,
    output logic pwm
);
    logic [7:0] duty_r, duty_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic pwm_r, pwm_nxt;

    always_comb
    begin
        duty_nxt = duty_r;
        cnt_nxt = cnt_r + 8'h01;
        if (!run)
        begin
            duty_nxt = 8'h00;
        end
        else if (cnt_r == 8'hFF)
        begin
            // step the duty once per pwm period; saturates at full on and off
            if (temp > target && duty_r != 8'hFF)
            begin
                duty_nxt = duty_r + 8'h01;
            end
            else if (temp < target && duty_r != 8'h00)
            begin
                duty_nxt = duty_r - 8'h01;
            end
        end
        pwm_nxt = run && (duty_r == 8'hFF || cnt_r < duty_r);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            duty_r <= 8'h00;
            cnt_r <= 8'h00;
            pwm_r <= 1'b0;
        end
        else
        begin
            duty_r <= duty_nxt;
            cnt_r <= cnt_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    assign pwm = pwm_r;
endmodule : pswc_fan

// file: testbench/pswc_panel.sv
// partner: front-panel power switch held down for a requested count of cycles
`timescale 1ns/1ps
module pswc_panel (
    input wire logic ref_clk,
    input wire logic press_go,
    input wire logic [7:0] press_len,
    output logic pwr_switch
);
    logic [7:0] left_r = 8'h00;
    // the press length is exact, so short and held presses are told apart
    always_ff @(posedge ref_clk)
    begin
        left_r <= press_go ? press_len : left_r - 8'(left_r != 8'h00);
    end
    assign pwr_switch = left_r != 8'h00;
endmodule : pswc_panel

// file: testbench/pswc_top_assertions.sv
// checker: port-level assertions for the power-state wake controller
`timescale 1ns/1ps
module pswc_chk #(
    parameter logic [pswc_pkg::HOLD_CW-1:0] HOLD_CYC = 26'h000_0032
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic pwr_switch,
    input wire logic rtc_alarm,
    input wire logic kbms_act,
    input wire logic cover_closed,
    input wire logic [3:0] rail_high,
    input wire logic [3:0] rail_low,
    input wire pswc_pkg::pswc_state_t sys_state,
    input wire logic main_power_on,
    input wire logic intrusion,
    input wire logic volt_fault,
    input wire logic [2:0] fan_pwm
);
    import pswc_pkg::*;
    int hold_r;
    int hold_nxt;
    logic sw_r;
    logic s5p_r;
    logic s5p_nxt;
    logic awake;
    assign awake = sys_state == PS_S0 || sys_state == PS_S1;
    // hold_r counts pressed cycles outside soft-off; s5p_r marks a press begun in soft-off
    always_comb
    begin
        hold_nxt = (pwr_switch && sys_state != PS_S5) ? hold_r + 1 : 0;
        s5p_nxt = pwr_switch && (s5p_r || (!sw_r && sys_state == PS_S5));
    end
    always_ff @(posedge ref_clk)
    begin
        hold_r <= rstn ? hold_nxt : 0;
        sw_r <= rstn && pwr_switch;
        s5p_r <= rstn && s5p_nxt;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_power_map: assert property (main_power_on == awake)
        else $error("main power does not match the state");
    a_fan_gated: assert property (!awake && !$past(awake) |-> fan_pwm == 3'h0)
        else $error("fan driven outside working states");
    a_intrude_copy: assert property ($past(rstn) |-> intrusion == $past(cover_closed))
        else $error("intrusion does not follow the cover switch");
    a_volt_window: assert property ($past(rstn) |-> volt_fault == $past(|(rail_high | rail_low)))
        else $error("supply fault does not follow the rails");
    a_rdata_idle: assert property ($past(rstn) && !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    a_hold_bound: assert property (hold_r <= int'(HOLD_CYC) + 4)
        else $error("held switch did not force soft-off");
    a_short_on: assert property (s5p_r && !pwr_switch |-> ##[1:3] sys_state == PS_S0)
        else $error("short press did not power on");
    a_kbd_wake: assert property (sys_state == PS_S3 && kbms_act |-> ##[1:2] sys_state == PS_S0)
        else $error("keyboard did not wake from suspend");
    a_rtc_wake: assert property (sys_state == PS_S5 && rtc_alarm |-> ##[1:2] sys_state == PS_S0)
        else $error("alarm did not wake from soft-off");
    c_sleep_wake: cover property (sys_state == PS_S1 ##1 sys_state == PS_S0);
    c_long_hold: cover property (hold_r == int'(HOLD_CYC));
    c_intrusion: cover property ($rose(intrusion));
endmodule : pswc_chk
bind pswc_top pswc_chk #(.HOLD_CYC(HOLD_CYC)) pswc_chk_i (.ref_clk(ref_clk), .rstn(rstn),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwr_switch(pwr_switch), .rtc_alarm(rtc_alarm),
    .kbms_act(kbms_act), .cover_closed(cover_closed), .rail_high(rail_high), .rail_low(rail_low),
    .sys_state(sys_state), .main_power_on(main_power_on), .intrusion(intrusion),
    .volt_fault(volt_fault), .fan_pwm(fan_pwm));

// file: testbench/tb_pswc_top.sv
// testbench: wake table, switch timing, commands, sensors, interrupt, fans
`timescale 1ns/1ps
module tb_pswc_top;
    import pswc_pkg::*;
    typedef struct {logic [2:0] cmd; int src; logic [1:0] cfg; pswc_state_t exp;} pswc_row_t;
    logic ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, press_go = 1'b0;
    logic cover_closed = 1'b0, pwr_switch, main_power_on, intrusion, volt_fault, irq;
    logic [3:0] reg_addr = 4'h0, rail_high = 4'h0, rail_low = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_v;
    logic [7:0] press_len = 8'h00;
    logic [6:0] wk = 7'h00;
    logic [23:0] fan_temp = 24'h00_0000;
    logic [2:0] fan_pwm;
    pswc_state_t sys_state;
    int miscompares = 0, tests_run = 0, k;
    // wake source index: 0 rtc 1 pcie 2 lan 3 pme 4 kbms 5 serial 6 usb
    pswc_row_t rows [14] = '{'{CMD_SOFT_OFF, 2, 2'h0, PS_S5}, '{CMD_SOFT_OFF, 2, 2'h1, PS_S0},
        '{CMD_SLEEP_S4, 2, 2'h0, PS_S0}, '{CMD_SLEEP_S3, 3, 2'h2, PS_S0}, '{CMD_SLEEP_S3, 3, 2'h0, PS_S3},
        '{CMD_SOFT_OFF, 3, 2'h3, PS_S0}, '{CMD_SOFT_OFF, 3, 2'h2, PS_S5}, '{CMD_SOFT_OFF, 0, 2'h0, PS_S0},
        '{CMD_SLEEP_S4, 1, 2'h0, PS_S0}, '{CMD_SOFT_OFF, 1, 2'h0, PS_S0}, '{CMD_SLEEP_S3, 4, 2'h0, PS_S0},
        '{CMD_SLEEP_S1, 5, 2'h0, PS_S0}, '{CMD_SOFT_OFF, 4, 2'h0, PS_S5}, '{CMD_SLEEP_S4, 6, 2'h0, PS_S4}};
    pswc_top #(.HOLD_CYC(26'h000_0032)) pswc_top_i (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pwr_switch(pwr_switch), .rtc_alarm(wk[0]), .pcie_wake(wk[1]), .lan_wake(wk[2]), .pme_wake(wk[3]),
        .kbms_act(wk[4]), .serial_act(wk[5]), .usb_act(wk[6]), .cover_closed(cover_closed),
        .rail_high(rail_high), .rail_low(rail_low), .fan_temp(fan_temp), .sys_state(sys_state),
        .main_power_on(main_power_on), .intrusion(intrusion), .volt_fault(volt_fault), .fan_pwm(fan_pwm),
        .irq(irq));
    pswc_panel pswc_panel_i (.ref_clk(ref_clk), .press_go(press_go), .press_len(press_len),
        .pwr_switch(pwr_switch));
    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask : rd
    task press(input logic [7:0] n);
        @(posedge ref_clk);
        press_go <= 1'b1;
        press_len <= n;
        @(posedge ref_clk);
        press_go <= 1'b0;
        repeat (n + 5) @(posedge ref_clk);
    endtask : press
    task pulse(input int b);
        @(posedge ref_clk);
        wk[b] <= 1'b1;
        @(posedge ref_clk);
        wk[b] <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : pulse
    task st(input pswc_state_t e);
        #1 chk("state", 16'(sys_state), 16'(e));
    endtask : st
    task wrap_up;
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        wrap_up();
    end
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        st(PS_S5);
        rd(OFS_CFG);
        chk("cfg reset", rd_v, 16'h0000);
        rd(4'h9);
        chk("unmapped", rd_v, 16'h0000);
        wr(OFS_CMD, 16'(CMD_SLEEP_S1));
        st(PS_S5);
        press(8'h03);
        st(PS_S0);
        press(8'h03);
        st(PS_S1);
        press(8'h03);
        st(PS_S0);
        press(8'h37);
        st(PS_S5);
        rd(OFS_STATUS);
        chk("forced", 16'(rd_v[ST_FORCED]), 16'h0001);
        press(8'h03);
        press(8'h03);
        press(8'h37);
        st(PS_S5);
        pulse(0);
        wr(OFS_CMD, 16'(CMD_SOFT_OFF));
        st(PS_S5);
        foreach (rows[i])
        begin
            pulse(0);
            wr(OFS_CFG, 16'(rows[i].cfg));
            wr(OFS_CMD, 16'(rows[i].cmd));
            pulse(rows[i].src);
            st(rows[i].exp);
        end
        @(posedge ref_clk);
        cover_closed <= 1'b1;
        rail_low <= 4'h4;
        rail_high <= 4'h1;
        repeat (3) @(posedge ref_clk);
        #1 chk("intrusion", 16'(intrusion), 16'h0001);
        chk("volt", 16'(volt_fault), 16'h0001);
        rd(OFS_LIVE);
        chk("live", rd_v, 16'h0A01);
        chk("irq masked", 16'(irq), 16'h0000);
        wr(OFS_MASK, 16'h0100);
        repeat (2) @(posedge ref_clk);
        #1 chk("irq on", 16'(irq), 16'h0001);
        @(posedge ref_clk);
        cover_closed <= 1'b0;
        rail_low <= 4'h0;
        rail_high <= 4'h0;
        repeat (3) @(posedge ref_clk);
        rd(OFS_STATUS);
        chk("sticky", rd_v & 16'h0300, 16'h0300);
        rd(OFS_STATUS);
        chk("cleared", rd_v & 16'h0300, 16'h0000);
        repeat (2) @(posedge ref_clk);
        #1 chk("irq off", 16'(irq), 16'h0000);
        pulse(0);
        wr(OFS_FAN0, 16'h0000);
        @(posedge ref_clk);
        fan_temp <= 24'hFF_FFFF;
        k = 0;
        while (fan_pwm[0] !== 1'b1 && k < 20000)
        begin
            @(posedge ref_clk);
            #1 k++;
        end
        chk("fan run", 16'(fan_pwm), 16'h0007);
        wr(OFS_CMD, 16'(CMD_SLEEP_S3));
        repeat (2) @(posedge ref_clk);
        #1 chk("fan off", 16'(fan_pwm), 16'h0000);
        st(PS_S3);
        rd(OFS_STATE);
        chk("state reg", rd_v, 16'(PS_S3));
        wr(OFS_CFG, 16'h0003);
        rd(OFS_CFG);
        chk("cfg set", rd_v, 16'h0003);
        rstn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        st(PS_S5);
        chk("irq reset", 16'(irq), 16'h0000);
        rd(OFS_CFG);
        chk("cfg re-reset", rd_v, 16'h0000);
        wrap_up();
    end
endmodule : tb_pswc_top
